/* File: logic/tag_bus_decoder.sv */
// drive-side tag bus decoder with AXI4-Lite register access
// assumes tag, bus and unit-select pins are asynchronous and are
// synchronised here; the controller keeps the bus stable during a tag
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
// What this block does
// - cylinder tag loads ten-bit address, head tag head
// - control tag decodes bits 0 to 8
// - narrow-head variant ignores extra head, control bits
// - fixed-track variant ignores servo offset bits
// - cartridge variant latches head bit 4 volume
// - volume switches only on valid cylinder tag
// - volume zero cartridge, one fixed disks
// - narrow-head without auto seek, head change waits seek
// - narrow-head with auto seek, head change starts zero seek
// - radial lines driven regardless of unit selection
// - seek error holds seek end asserted
// - drive sources servo, read, seek end, selected
// - head tag precedes cylinder tag, switch trailing
module tag_bus_decoder #(
  parameter int cyl_max = 1023
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [9:0] bus_in,
  input wire logic cyl_tag_in,
  input wire logic head_tag_in,
  input wire logic ctl_tag_in,
  input wire logic [3:0] unit_sel_in,
  input wire logic servo_clk_in,
  input wire logic read_data_in,
  input wire logic read_clk_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output tag_bus_pkg::radial_t radial_out,
  output tag_bus_pkg::control_t control_out,
  output logic volume_fixed_out,
  output logic seek_start_out,
  output logic irq_out
);
  typedef struct packed
  {
    logic [31:0] ctrl;
    logic [9:0] cyl;
    logic [4:0] head;
    logic [4:0] head_pend;
    logic pend;
    logic vol_latch;
    logic volume;
    tag_bus_pkg::control_t cmd;
    logic [2:0] tags_q;
    logic [1:0] pulse_cnt;
    logic seek_end;
    logic seek_start;
    logic [tag_bus_pkg::irq_width-1:0] irq_stat;
    logic [tag_bus_pkg::irq_width-1:0] irq_mask;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    tag_bus_pkg::radial_t radial;
  } state_t;

  state_t st;
  state_t next_st;
  logic [9:0] bus_s;
  logic [2:0] tags_s;
  logic [3:0] unit_s;
  logic [2:0] clk_s;

  // every bus, tag, unit-select and clock pin crosses two flops before use
  tag_sync #(.width(20)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({bus_in, cyl_tag_in, head_tag_in, ctl_tag_in, unit_sel_in,
      servo_clk_in, read_data_in, read_clk_in}),
    .sync_out({bus_s, tags_s, unit_s, clk_s})
  );

  // register read mux, shared by read path
  function automatic logic [31:0] reg_read(input state_t s,
    input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      tag_bus_pkg::ctrl_offset: v = s.ctrl;
      tag_bus_pkg::stat_offset:
        v = {24'h00_0000, s.pend, s.seek_end, s.volume, s.vol_latch,
          4'h0};
      tag_bus_pkg::cyl_offset: v = {22'h00_0000, s.cyl};
      tag_bus_pkg::head_offset: v = {22'h00_0000, s.head_pend, s.head};
      tag_bus_pkg::cmd_offset: v = {23'h00_0000, s.cmd};
      tag_bus_pkg::irq_stat_offset: v = {28'h000_0000, s.irq_stat};
      tag_bus_pkg::irq_mask_offset: v = {28'h000_0000, s.irq_mask};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a <= tag_bus_pkg::irq_mask_offset && a[1:0] == 2'h0;
  endfunction

  // tag edges, variant handling, bus slave
  always_comb
  begin
    logic [2:0] fall;
    logic selected;
    logic [1:0] variant;
    logic [tag_bus_pkg::irq_width-1:0] ev;
    logic [31:0] wd;
    tag_bus_pkg::control_t c;
    next_st = st;
    c = '0;
    wd = st.w_data;
    ev = '0;
    variant = st.ctrl[tag_bus_pkg::ctrl_variant_lsb +: 2];
    selected = unit_s == st.ctrl[tag_bus_pkg::ctrl_unit_lsb +: 4];
    // trailing edges: tag acts once bus has been stable throughout
    fall = st.tags_q & ~tags_s;
    next_st.tags_q = tags_s;
    next_st.seek_start = 1'b0;
    if (selected && fall[1])
    begin
      if (variant == 2'(tag_bus_pkg::variant_narrow_head))
        next_st.head_pend = {2'b00, bus_s[2:0]};
      else if (variant == 2'(tag_bus_pkg::variant_cart_fixed))
      begin
        next_st.head_pend = {2'b00, bus_s[2:0]};
        next_st.vol_latch = bus_s[tag_bus_pkg::volume_bit];
      end
      else
        next_st.head_pend = bus_s[4:0];
      ev[tag_bus_pkg::irq_head_bit] = 1'b1;
      if (variant == 2'(tag_bus_pkg::variant_narrow_head) &&
        st.ctrl[tag_bus_pkg::ctrl_auto_seek_bit])
      begin
        next_st.head = (variant == 2'(tag_bus_pkg::variant_narrow_head)) ?
          {2'b00, bus_s[2:0]} : bus_s[4:0];
        next_st.seek_start = 1'b1;
        next_st.pend = 1'b0;
      end
      else if (variant == 2'(tag_bus_pkg::variant_narrow_head))
        // hold head change for the next seek
        next_st.pend = 1'b1;
      else
        next_st.head = next_st.head_pend;
    end
    if (selected && fall[2])
    begin
      // ten-bit cylinder address, bit n weight 2^n
      if (bus_s <= 10'(cyl_max))
      begin
        next_st.cyl = bus_s;
        next_st.seek_start = 1'b1;
        if (st.pend)
        begin
          next_st.head = st.head_pend;
          next_st.pend = 1'b0;
        end
        // volume switch at cylinder tag end
        // servo head follows at cylinder tag trailing edge
        if (variant == 2'(tag_bus_pkg::variant_cart_fixed) &&
          st.volume != st.vol_latch)
        begin
          next_st.volume = st.vol_latch;
          ev[tag_bus_pkg::irq_vol_bit] = 1'b1;
        end
      end
      ev[tag_bus_pkg::irq_cyl_bit] = 1'b1;
    end
    if (selected && fall[0])
    begin
      c = bus_s[8:0];
      if (variant == 2'(tag_bus_pkg::variant_narrow_head))
        c.address_mark_enable = 1'b0;
      // no servo offsets on fixed track
      if (variant == 2'(tag_bus_pkg::variant_fixed_track))
      begin
        c.offset_plus = 1'b0;
        c.offset_minus = 1'b0;
      end
      next_st.cmd = c;
      if (c.return_to_track_zero)
        next_st.seek_start = 1'b1;
      ev[tag_bus_pkg::irq_cmd_bit] = 1'b1;
    end
    // seek error holds seek end, else short pulse
    if (st.ctrl[tag_bus_pkg::ctrl_seek_err_bit])
      next_st.seek_end = 1'b1;
    else if (st.pulse_cnt != 2'h0)
    begin
      next_st.pulse_cnt = st.pulse_cnt - 2'h1;
      next_st.seek_end = 1'b1;
    end
    else
      next_st.seek_end = 1'b0;
    if (st.ctrl[tag_bus_pkg::ctrl_seek_done_bit] && !st.seek_end)
      next_st.pulse_cnt = 2'(tag_bus_pkg::seek_pulse_cycles);
    // radial lines not gated by unit select
    next_st.radial.servo_clock = clk_s[2];
    next_st.radial.read_data = clk_s[1];
    next_st.radial.read_clock = clk_s[0];
    next_st.radial.seek_end = st.seek_end;
    next_st.radial.unit_selected = selected;
    // write channel: address and data in either order
    if (s_axi_awvalid && !st.aw_got)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st.w_got)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata;
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.aw_addr) ? tag_bus_pkg::resp_okay :
        tag_bus_pkg::resp_slverr;
      if (st.aw_addr == tag_bus_pkg::ctrl_offset)
        next_st.ctrl = wd;
      if (st.aw_addr == tag_bus_pkg::irq_mask_offset)
        next_st.irq_mask = wd[tag_bus_pkg::irq_width-1:0];
      if (st.aw_addr == tag_bus_pkg::irq_stat_offset)
        next_st.irq_stat = st.irq_stat & ~wd[tag_bus_pkg::irq_width-1:0];
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // set wins over write-one clear
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    // read channel
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_read(st, s_axi_araddr[7:0]);
      next_st.rresp = is_mapped(s_axi_araddr[7:0]) ?
        tag_bus_pkg::resp_okay : tag_bus_pkg::resp_slverr;
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
  end

  // all state in one register
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = !st.aw_got;
  assign s_axi_wready = !st.w_got;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign radial_out = st.radial;
  assign control_out = st.cmd;
  assign volume_fixed_out = st.volume;
  assign seek_start_out = st.seek_start;
  assign irq_out = st.irq;

  // seek error keeps seek end high
  a_seek_err_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    st.ctrl[tag_bus_pkg::ctrl_seek_err_bit] |=> ##1 radial_out.seek_end)
    else $error("seek end not held on seek error");
  // offsets stay clear on fixed track
  a_no_offset_fixed: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $changed(control_out) && st.ctrl[1:0] == 2'b01 |->
    !control_out.offset_plus && !control_out.offset_minus)
    else $error("servo offset acted on fixed track variant");
  // volume changes only with cylinder tag end
  a_volume_on_cyl: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $changed(volume_fixed_out) |-> $past(st.tags_q[2]))
    else $error("volume changed without cylinder tag");

  // head tag end for this unit on narrow-head variant
  sequence narrow_head_end;
    st.tags_q[1] && !tags_s[1] &&
      unit_s == st.ctrl[tag_bus_pkg::ctrl_unit_lsb +: 4] &&
      st.ctrl[tag_bus_pkg::ctrl_variant_lsb +: 2] ==
      2'(tag_bus_pkg::variant_narrow_head);
  endsequence

  // upper head bits never reach the pending head
  a_narrow_head_bits: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    narrow_head_end |=> st.head_pend[4:3] == 2'b00)
    else $error("narrow head variant kept upper head bits");
  // without auto seek the head change only goes pending
  a_head_deferred: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    narrow_head_end ##0 !st.ctrl[tag_bus_pkg::ctrl_auto_seek_bit] |=>
    st.pend && $stable(st.head))
    else $error("head changed before the next seek");
  // auto seek applies the head at once with a zero seek
  a_head_auto_seek: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    narrow_head_end ##0 st.ctrl[tag_bus_pkg::ctrl_auto_seek_bit] |=>
    st.seek_start && !st.pend && st.head == st.head_pend)
    else $error("head change did not start a zero seek");
  // tags from other units leave command and cylinder alone
  a_unsel_ignored: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    unit_s != st.ctrl[tag_bus_pkg::ctrl_unit_lsb +: 4] |=>
    $stable(st.cmd) && $stable(st.cyl))
    else $error("tag acted on while unit not selected");
endmodule

/* File: logic/tag_bus_pkg.sv */
// package for the drive-side tag bus decoder: register map, fields, types
// assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock
package tag_bus_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] stat_offset = 8'h04;
  localparam logic [7:0] cyl_offset = 8'h08;
  localparam logic [7:0] head_offset = 8'h0c;
  localparam logic [7:0] cmd_offset = 8'h10;
  localparam logic [7:0] irq_stat_offset = 8'h14;
  localparam logic [7:0] irq_mask_offset = 8'h18;
  // control register fields
  localparam int ctrl_variant_lsb = 0;
  localparam int ctrl_auto_seek_bit = 2;
  localparam int ctrl_unit_lsb = 4;
  localparam int ctrl_seek_err_bit = 8;
  localparam int ctrl_seek_done_bit = 9;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  // interrupt event bits
  localparam int irq_cyl_bit = 0;
  localparam int irq_head_bit = 1;
  localparam int irq_cmd_bit = 2;
  localparam int irq_vol_bit = 3;
  localparam int irq_width = 4;
  // head bits used by the narrow-head variant, and the cartridge volume head bit
  localparam int narrow_head_bits = 3;
  localparam int volume_bit = 4;
  // seek-end pulse length
  localparam int seek_pulse_ns = 16;
  localparam int clk_period_ns = 8;
  localparam int seek_pulse_cycles = seek_pulse_ns / clk_period_ns;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // drive variants
  typedef enum logic [1:0]
  {
    variant_moving = 2'b00,
    variant_fixed_track = 2'b01,
    variant_cart_fixed = 2'b10,
    variant_narrow_head = 2'b11
  } variant_t;

  // decoded control tag
  typedef struct packed
  {
    logic strobe_late;
    logic strobe_early;
    logic return_to_track_zero;
    logic address_mark_enable;
    logic fault_clear;
    logic offset_minus;
    logic offset_plus;
    logic read_gate;
    logic write_gate;
  } control_t;

  // radial cable lines sourced by the drive
  typedef struct packed
  {
    logic servo_clock;
    logic read_data;
    logic read_clock;
    logic seek_end;
    logic unit_selected;
  } radial_t;
endpackage

/* File: logic/tag_sync.sv */
// two-flop synchroniser bank for pins from outside the clock domain
// assumes an asynchronous active-low reset
`timescale 1ns/10ps
module tag_sync #(
  parameter int width = 1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* File: verification/tag_ctl_model.sv */
// controller model: drives the ten bus lines and the three tags
// assumes the drive samples the strobes with its own clock
`timescale 1ns/10ps
module tag_ctl_model (
  input wire logic clk_in,
  output logic [9:0] bus_out,
  output logic [2:0] tag_out
);
  initial
  begin
    bus_out = 10'h000;
    tag_out = 3'h0;
  end

  task automatic send(input int k, input logic [9:0] v);
    @(posedge clk_in);
    bus_out <= v;
    tag_out <= 3'(1 << k);
    repeat (4) @(posedge clk_in);
    tag_out <= 3'h0;
    repeat (2) @(posedge clk_in);
    // a released bus shows the inverse so stale data cannot pass
    bus_out <= ~v;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

/* File: verification/disk_tag_bus_decoder_bench.sv */
// bench for the tag bus decoder: tags, registers, interrupt
// assumes the controller model and AXI4-Lite write-then-answer timing
`timescale 1ns/10ps
`define chk(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: %h %h", $time, (a), (b)); end end
module disk_tag_bus_decoder_bench;
  logic clk_in = 0, rst_b_in = 0, servo = 0, s0, s1, a;
  logic [3:0] usel = 4'h3;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rv;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, vol, seek, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [9:0] bus, b, c;
  logic [2:0] tag;
  tag_bus_pkg::radial_t rad;
  tag_bus_pkg::control_t ctl;
  int n_mismatch = 0, checks = 0, cyc = 0, nseek = 0, n;

  tag_ctl_model i_ctl (.clk_in(clk_in), .bus_out(bus), .tag_out(tag));
  tag_bus_decoder #(.cyl_max(1000)) i_dut (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .bus_in(bus), .cyl_tag_in(tag[0]),
    .head_tag_in(tag[1]), .ctl_tag_in(tag[2]), .unit_sel_in(usel),
    .servo_clk_in(servo), .read_data_in(servo), .read_clk_in(~servo),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .radial_out(rad), .control_out(ctl),
    .volume_fixed_out(vol), .seek_start_out(seek), .irq_out(irq));

  // system clock, and a free-running 160 ns servo clock
  initial
  begin
    forever #4 clk_in = ~clk_in;
  end
  initial
  begin
    forever #80 servo = ~servo;
  end

  // seek pulse counter and hang limit
  always @(posedge clk_in)
  begin
    cyc++;
    if (seek === 1'b1) nseek++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    awaddr <= {24'h0, ad};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask

  task automatic rd(input logic [7:0] ad);
    @(posedge clk_in);
    araddr <= {24'h0, ad};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata;
    rsp = rresp;
  endtask

  // unit 3 always, so tags are accepted while usel is 3
  task automatic cfg(input logic [1:0] v, input logic au);
    wr(tag_bus_pkg::ctrl_offset, {26'h0, 2'h3, 1'b0, au, v});
  endtask

  function automatic logic [8:0] exp_ctl(int v, logic [9:0] x);
    logic [8:0] e;
    e = x[8:0];
    if (v == 1) e[3:2] = 2'b00;
    if (v == 3) e[5] = 1'b0;
    return e;
  endfunction

  initial
  begin
    void'($urandom(91600));
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(tag_bus_pkg::ctrl_offset);
    `chk(rv, tag_bus_pkg::ctrl_reset)
    rd(8'h40);
    `chk(rsp, tag_bus_pkg::resp_slverr)
    // control decode in every variant, all-ones as the corner
    for (int v = 0; v < 4; v++)
    begin
      cfg(2'(v), 1'b0);
      b = (v == 0) ? 10'h3ff : 10'($urandom);
      i_ctl.send(2, b);
      `chk(ctl, exp_ctl(v, b))
    end
    // other unit selected: tags ignored, cable still driven
    usel <= 4'h5;
    i_ctl.send(2, ~b);
    `chk(ctl, exp_ctl(3, b))
    s0 = 0;
    s1 = 0;
    a = 0;
    repeat (60)
    begin
      @(posedge clk_in);
      s0 = s0 | !rad.servo_clock;
      s1 = s1 | rad.servo_clock;
      a = a | (rad.read_data ^ rad.servo_clock) |
        (rad.read_clock ~^ rad.servo_clock);
    end
    `chk(s0 & s1, 1'b1)
    `chk(a, 1'b0)
    `chk(rad.unit_selected, 1'b0)
    usel <= 4'h3;
    cfg(2'h0, 1'b0);
    c = 10'($urandom_range(999));
    i_ctl.send(0, c);
    `chk(rad.unit_selected, 1'b1)
    rd(tag_bus_pkg::cyl_offset);
    `chk(rv[9:0], c)
    i_ctl.send(0, 10'h3f2);
    rd(tag_bus_pkg::cyl_offset);
    `chk(rv[9:0], c)
    // volume: head tag latches, valid cylinder tag switches
    cfg(2'h2, 1'b0);
    i_ctl.send(1, 10'h010);
    `chk(vol, 1'b0)
    i_ctl.send(0, 10'h3f2);
    `chk(vol, 1'b0)
    i_ctl.send(0, c);
    `chk(vol, 1'b1)
    i_ctl.send(1, 10'h000);
    i_ctl.send(0, c);
    `chk(vol, 1'b0)
    // head change with and without the automatic seek
    cfg(2'h3, 1'b0);
    n = nseek;
    i_ctl.send(1, 10'h005);
    `chk(nseek - n, 0)
    rd(tag_bus_pkg::head_offset);
    `chk(rv[9:0], 10'h0a0)
    i_ctl.send(0, c);
    `chk(nseek - n, 1)
    rd(tag_bus_pkg::head_offset);
    `chk(rv[4:0], 5'h05)
    cfg(2'h3, 1'b1);
    n = nseek;
    i_ctl.send(1, 10'h002);
    `chk(nseek - n, 1)
    // seek error keeps seek end high
    wr(tag_bus_pkg::ctrl_offset, 32'h0000_0130);
    // seek end reaches the cable two edges after the control write
    repeat (2) @(posedge clk_in);
    s1 = 1;
    repeat (20)
    begin
      @(posedge clk_in);
      s1 = s1 & rad.seek_end;
    end
    `chk(s1, 1'b1)
    cfg(2'h0, 1'b0);
    // interrupt: raised by tags, masked, cleared by writing ones
    rd(tag_bus_pkg::irq_stat_offset);
    `chk(rv[0], 1'b1)
    wr(tag_bus_pkg::irq_mask_offset, 32'h0);
    repeat (3) @(posedge clk_in);
    `chk(irq, 1'b0)
    wr(tag_bus_pkg::irq_mask_offset, 32'hf);
    repeat (3) @(posedge clk_in);
    `chk(irq, 1'b1)
    wr(tag_bus_pkg::irq_stat_offset, 32'hf);
    repeat (3) @(posedge clk_in);
    rd(tag_bus_pkg::irq_stat_offset);
    `chk(rv[3:0], 4'h0)
    `chk(irq, 1'b0)
    close_out();
  end
endmodule
